// ===== dv/rtcai_host.sv
// host model on the strobe register port
// assumes the bench calls xfer after reset
`timescale 1ns/1ps
module rtcai_host (
  input wire logic clock_i,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic [6:0] reg_addr_o = 7'h00,
  output logic [7:0] reg_wdata_o = 8'h00
);
  // released bus shows the inverse of the last value
  task xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    reg_wr_o = w;
    reg_rd_o = !w;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clock_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// ===== dv/rtcai_monitor.sv
// port checker for rtcai_ctrl
// assumes a bind from the bench top file
`timescale 1ns/1ps
module rtcai_monitor (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic osc_raw_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic osc_clean_o,
  input wire logic first_irq_out_n_o,
  input wire logic second_irq_out_n_o
);
  logic [7:0] ctl_ff;
  logic raw_ff;
  logic [10:0] cnt_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of the control register and age of the raw oscillator level
  always_ff @(posedge clock_i) begin
    raw_ff <= osc_raw_i;
    if (!rst_n_i || osc_raw_i != raw_ff) cnt_ff <= 11'h000;
    else if (cnt_ff != 11'h7ff) cnt_ff <= cnt_ff + 11'h001;
    if (!rst_n_i) ctl_ff <= 8'h80;
    else if (reg_wr_i && reg_addr_i == 7'h0f) ctl_ff <= reg_wdata_i & 8'hbf;
  end
  reset_idle_a: assert property (disable iff (1'b0) !rst_n_i |=>
    first_irq_out_n_o && second_irq_out_n_o && reg_rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  ctl_read_a: assert property (reg_rd_i && reg_addr_i == 7'h0f |=>
    reg_rdata_o == $past(ctl_ff)) else $error("control read wrong");
  shared_pin_a: assert property ($stable(ctl_ff) && ctl_ff[3:2] == 2'h0
    |-> second_irq_out_n_o) else $error("second pin low when shared");
  zero_gate_a: assert property ($stable(ctl_ff) && ctl_ff[1:0] == 2'h0
    |-> first_irq_out_n_o) else $error("first pin low, alarms off");
  one_gate_a: assert property ($stable(ctl_ff) && ctl_ff[3:1] == 3'h2
    |-> second_irq_out_n_o) else $error("second pin low, alarm 1 off");
  square_out_a: assert property ($stable(ctl_ff) && ctl_ff[3] |->
    second_irq_out_n_o == $past(osc_clean_o)) else $error("no square wave");
  stop_masked_a: assert property (reg_rd_i && reg_addr_i == 7'h10 &&
    $stable(ctl_ff) && ctl_ff[5] |=> !reg_rdata_o[7])
    else $error("stop flag set while disabled");
  filter_hold_a: assert property (ctl_ff[4] && $stable(ctl_ff) &&
    $changed(osc_clean_o) |-> cnt_ff >= 11'h3e3)
    else $error("filter passed a short level");
endmodule

// ===== dv/tb_rtc_alarm_interrupt_control.sv
// self-checking bench for rtcai_ctrl
// assumes the host model and the checker are compiled first
`timescale 1ns/1ps
module tb_rtc_alarm_interrupt_control;
  logic clock_i = 1'b0, rst_n_i = 1'b0, tick = 1'b0, osc = 1'b0, pend = 1'b0;
  logic wr, rd, fi, si, clean, off;
  logic [6:0] ad;
  logic [7:0] wd, rdat, s, tsec = 8'h00;
  logic [7:0] expq[$];
  int miscompares = 0, comparisons = 0, seed = 29;
  always #2.5 clock_i = ~clock_i;
  rtcai_host host (.clock_i(clock_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(ad), .reg_wdata_o(wd));
  rtcai_ctrl #(.OSC_STOP_CYCLES(50)) dut (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .sec_tick_i(tick),
    .time_sec_i(tsec), .time_min_i(8'h00), .time_hour_i(8'h00),
    .time_day_i(8'h00), .osc_raw_i(osc), .osc_clean_o(clean),
    .osc_off_on_battery_o(off), .first_irq_out_n_o(fi),
    .second_irq_out_n_o(si));
  task chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task rdx(input logic [6:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task irq(input logic f, input logic g);
    repeat (2) @(posedge clock_i);
    #1;
    chk("irq pins", {6'h00, fi, si}, {6'h00, f, g});
  endtask
  task tk(input logic [7:0] v);
    @(posedge clock_i);
    #1;
    tick = 1'b1;
    tsec = v;
    @(posedge clock_i);
    #1;
    tick = 1'b0;
  endtask
  always @(negedge clock_i) begin
    if (pend) chk("read data", rdat, expq.pop_front());
    pend = rd;
  end
  always begin
    repeat (1200) @(posedge clock_i);
    #1;
    osc = ~osc;
  end
  initial begin
    s = (8'($random(seed)) & 8'h6e) | 8'h10;
    repeat (3) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    rdx(7'h0f, 8'h80);
    chk("battery osc off", {7'h00, off}, 8'h01);
    rdx(7'h10, 8'h80);
    host.xfer(1'b1, 7'h0f, 8'hff);
    rdx(7'h0f, 8'hbf);
    rdx(7'h10, 8'h00);
    repeat (3000) @(posedge clock_i);
    #1;
    chk("filtered osc", {7'h00, clean}, {7'h00, ~osc});
    host.xfer(1'b1, 7'h0f, 8'h20);
    chk("battery osc off", {7'h00, off}, 8'h00);
    for (int i = 7; i < 15; i++) host.xfer(1'b1, 7'(i), i == 11 ? s : 8'h80);
    tk(s ^ 8'h01);
    irq(1'b1, 1'b1);
    rdx(7'h10, 8'h01);
    tk(s);
    rdx(7'h10, 8'h03);
    host.xfer(1'b1, 7'h0f, 8'h22);
    irq(1'b0, 1'b1);
    host.xfer(1'b1, 7'h0f, 8'h26);
    irq(1'b1, 1'b0);
    host.xfer(1'b1, 7'h0f, 8'h24);
    irq(1'b1, 1'b1);
    host.xfer(1'b1, 7'h0f, 8'h25);
    irq(1'b0, 1'b1);
    host.xfer(1'b1, 7'h10, 8'h00);
    irq(1'b1, 1'b1);
    chk("bypassed osc", {7'h00, clean}, {7'h00, osc});
    conclude();
  end
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule
bind rtcai_ctrl rtcai_monitor mon (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .osc_raw_i(osc_raw_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .osc_clean_o(osc_clean_o),
  .first_irq_out_n_o(first_irq_out_n_o),
  .second_irq_out_n_o(second_irq_out_n_o));

// ===== src/rtcai_ctrl.sv
// control register, alarm matching and interrupt routing of the rtc
// assumes timekeeping logic on clock_i gives time fields and a second tick
//
// Notes on behaviour
// - disable bit set: oscillator faults ignored, stop flag held 0; resets 0
// - glitch filter bit set: oscillator output needs 5us stability; resets 0
// - square wave bit set: 32kHz oscillator wave on second irq pin
// - routing bit 1: alarm 0 to first pin, alarm 1 to second unless square wave bit set
// - routing bit 0: either enabled alarm drives the first pin
// - alarm 1 enable gates its interrupt; resets to 0
// - alarm 1 match sets its request flag regardless of enable
// - alarm 0 interrupt only on first pin, gated by its enable; resets 0
// - alarm 0 match sets its request flag regardless of enable
// - per-field mask bits choose which of seconds/minutes/hours/day compare
`timescale 1ns/1ps
module rtcai_ctrl #(
  parameter int OSC_STOP_CYCLES = rtcai_pkg::OSC_STOP_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sec_tick_i,
  input wire logic [7:0] time_sec_i,
  input wire logic [7:0] time_min_i,
  input wire logic [7:0] time_hour_i,
  input wire logic [7:0] time_day_i,
  input wire logic osc_raw_i,
  output logic osc_clean_o,
  output logic osc_off_on_battery_o,
  output logic first_irq_out_n_o,
  output logic second_irq_out_n_o
);
  logic [7:0] ctrl_ff;
  logic [7:0] alarm_ff [8];
  logic alarm_zero_request_flag_ff;
  logic alarm_one_request_flag_ff;
  logic oscillator_stopped_flag_ff;
  logic [2:0] osc_sync_ff;
  logic osc_lvl_ff;
  logic osc_filt_ff;
  logic osc_prev_ff;
  logic [9:0] glitch_cnt_ff;
  logic [31:0] stop_cnt_ff;
  logic [7:0] rdata_ff;
  logic irq0_n_ff;
  logic irq1_n_ff;

  wire osc_stop_detect_disable = ctrl_ff[rtcai_pkg::CTRL_STOP_DIS_BIT];
  wire glitch_filter_enable = ctrl_ff[rtcai_pkg::CTRL_GFIL_BIT];
  wire square_wave_enable = ctrl_ff[rtcai_pkg::CTRL_SQUARE_BIT];
  wire alarm_routing_select = ctrl_ff[rtcai_pkg::CTRL_ROUTE_BIT];
  wire alarm_one_irq_enable = ctrl_ff[rtcai_pkg::CTRL_ALM1_EN_BIT];
  wire alarm_zero_irq_enable = ctrl_ff[rtcai_pkg::CTRL_ALM0_EN_BIT];

  wire ctrl_wr = reg_wr_i && (reg_addr_i == rtcai_pkg::CTRL_OFS);
  wire stat_wr = reg_wr_i && (reg_addr_i == rtcai_pkg::STAT_OFS);
  wire alarm_sel = (reg_addr_i >= rtcai_pkg::ALM0_SEC_OFS) &&
                   (reg_addr_i <= rtcai_pkg::ALM1_DAY_OFS);
  wire [6:0] alarm_ofs = reg_addr_i - rtcai_pkg::ALM0_SEC_OFS;
  wire [2:0] alarm_idx = alarm_ofs[2:0];

  // alarm field compare, masked fields always agree
  wire [7:0] time_fld [4];
  assign time_fld[0] = time_sec_i;
  assign time_fld[1] = time_min_i;
  assign time_fld[2] = time_hour_i;
  assign time_fld[3] = time_day_i;
  logic [1:0] match;
  genvar a;
  genvar f;
  generate
    for (a = 0; a < 2; a++) begin : g_alarm
      logic [3:0] fld_ok;
      for (f = 0; f < rtcai_pkg::ALM_FIELDS; f++) begin : g_fld
        assign fld_ok[f] = alarm_ff[a*4+f][rtcai_pkg::ALM_MASK_BIT] ||
                           (alarm_ff[a*4+f][6:0] == time_fld[f][6:0]);
      end
      assign match[a] = sec_tick_i && (&fld_ok);
    end
  endgenerate

  // request flags: set by match wins over a clearing write of 0
  wire clr_f0 = stat_wr && !reg_wdata_i[rtcai_pkg::STAT_F0_BIT];
  wire clr_f1 = stat_wr && !reg_wdata_i[rtcai_pkg::STAT_F1_BIT];
  wire clr_stop = stat_wr && !reg_wdata_i[rtcai_pkg::STAT_STOP_BIT];
  wire nxt_f0 = match[0] || (alarm_zero_request_flag_ff && !clr_f0);
  wire nxt_f1 = match[1] || (alarm_one_request_flag_ff && !clr_f1);

  // oscillator: edge counted once 2nd and 3rd sync stages agree
  wire osc_agree = (osc_sync_ff[1] == osc_sync_ff[2]);
  wire nxt_osc_lvl = osc_agree ? osc_sync_ff[2] : osc_lvl_ff;
  wire glitch_done = (glitch_cnt_ff == 10'(rtcai_pkg::GLITCH_CYC - 1));
  wire [9:0] nxt_glitch_cnt = (osc_lvl_ff == osc_filt_ff) ? 10'h000 :
                              glitch_done ? 10'h000 : glitch_cnt_ff + 10'h001;
  wire nxt_osc_filt = !glitch_filter_enable ? osc_lvl_ff :
                      glitch_done ? osc_lvl_ff : osc_filt_ff;
  wire osc_edge = (osc_filt_ff != osc_prev_ff);
  wire stop_hit = (stop_cnt_ff >= 32'(OSC_STOP_CYCLES - 1));
  wire [31:0] nxt_stop_cnt = osc_edge ? 32'h0000_0000 :
                             stop_hit ? stop_cnt_ff : stop_cnt_ff + 32'h1;
  wire nxt_stop_flag = !osc_stop_detect_disable &&
                       ((stop_hit && !osc_edge) ||
                        (oscillator_stopped_flag_ff && !clr_stop));

  // interrupt routing, active low
  wire irq0_act = alarm_zero_request_flag_ff && alarm_zero_irq_enable;
  wire irq1_act = alarm_one_request_flag_ff && alarm_one_irq_enable;
  wire nxt_irq0_n = alarm_routing_select ? !irq0_act :
                    !(irq0_act || irq1_act);
  wire nxt_irq1_n = square_wave_enable ? osc_filt_ff :
                    alarm_routing_select ? !irq1_act : 1'b1;

  wire [7:0] stat_rd = {oscillator_stopped_flag_ff, 5'h00,
                        alarm_one_request_flag_ff, alarm_zero_request_flag_ff};
  // unmapped addresses read as zero
  wire [7:0] nxt_rdata = !reg_rd_i ? rdata_ff :
                         alarm_sel ? alarm_ff[alarm_idx] :
                         (reg_addr_i == rtcai_pkg::CTRL_OFS) ? ctrl_ff :
                         (reg_addr_i == rtcai_pkg::STAT_OFS) ? stat_rd : 8'h00;

  generate
    for (a = 0; a < 8; a++) begin : g_alm_reg
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          alarm_ff[a] <= rtcai_pkg::ALM_RST;
        end else if (reg_wr_i && alarm_sel && alarm_idx == 3'(a)) begin
          alarm_ff[a] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= rtcai_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= reg_wdata_i & rtcai_pkg::CTRL_WMASK;
    end
  end

  // alarm request flags
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      alarm_zero_request_flag_ff <= 1'b0;
      alarm_one_request_flag_ff <= 1'b0;
    end else begin
      alarm_zero_request_flag_ff <= nxt_f0;
      alarm_one_request_flag_ff <= nxt_f1;
    end
  end

  // oscillator stop flag comes out of reset set
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      oscillator_stopped_flag_ff <= rtcai_pkg::STAT_STOP_RST;
    end else begin
      oscillator_stopped_flag_ff <= nxt_stop_flag;
    end
  end

  // three-stage synchroniser for the asynchronous oscillator pin
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      osc_sync_ff <= 3'h0;
      osc_lvl_ff <= 1'b0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_raw_i};
      osc_lvl_ff <= nxt_osc_lvl;
    end
  end

  // glitch filter and edge tracking
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      osc_filt_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
      glitch_cnt_ff <= 10'h000;
    end else begin
      osc_filt_ff <= nxt_osc_filt;
      osc_prev_ff <= osc_filt_ff;
      glitch_cnt_ff <= nxt_glitch_cnt;
    end
  end

  // cycles since the last clean oscillator edge, saturating
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stop_cnt_ff <= 32'h0000_0000;
    end else begin
      stop_cnt_ff <= nxt_stop_cnt;
    end
  end

  // read data register holds until the next read strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // interrupt pins idle high out of reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq0_n_ff <= 1'b1;
      irq1_n_ff <= 1'b1;
    end else begin
      irq0_n_ff <= nxt_irq0_n;
      irq1_n_ff <= nxt_irq1_n;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign osc_clean_o = osc_filt_ff;
  assign osc_off_on_battery_o = ctrl_ff[rtcai_pkg::CTRL_OSC_OFF_BIT];
  assign first_irq_out_n_o = irq0_n_ff;
  assign second_irq_out_n_o = irq1_n_ff;
endmodule

// ===== src/rtcai_pkg.sv
// constants for the alarm / oscillator control block of the rtc
// assumes a 200 MHz system clock and an 8-bit register port
package rtcai_pkg;
  localparam logic [6:0] ALM0_SEC_OFS = 7'h07;
  localparam logic [6:0] ALM1_DAY_OFS = 7'h0e;
  localparam logic [6:0] CTRL_OFS = 7'h0f;
  localparam logic [6:0] STAT_OFS = 7'h10;
  // control register fields
  localparam int CTRL_OSC_OFF_BIT = 7;
  localparam int CTRL_STOP_DIS_BIT = 5;
  localparam int CTRL_GFIL_BIT = 4;
  localparam int CTRL_SQUARE_BIT = 3;
  localparam int CTRL_ROUTE_BIT = 2;
  localparam int CTRL_ALM1_EN_BIT = 1;
  localparam int CTRL_ALM0_EN_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  localparam logic [7:0] CTRL_RST = 8'h80;
  // status register fields
  localparam int STAT_STOP_BIT = 7;
  localparam int STAT_F1_BIT = 1;
  localparam int STAT_F0_BIT = 0;
  localparam logic STAT_STOP_RST = 1'b1;
  localparam logic [7:0] ALM_RST = 8'h00;
  // alarm fields: bit 7 is the mask, bits 6:0 compare
  localparam int ALM_MASK_BIT = 7;
  localparam int ALM_FIELDS = 4;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int GLITCH_NS = 5000;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_STOP_NS = 100000;
  localparam int OSC_STOP_CYC = OSC_STOP_NS / CLK_PERIOD_NS;
endpackage
